// >>> can_output_signal_packer.sv
// Output message packer with its frame FIFO
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "packer_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Plain synchronous FIFO with valid and ready on both sides
module frame_fifo #(
    parameter int W = 89,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] count
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic push;
    logic pop;

    // Honest flags straight from the count
    assign in_ready = (count != (AW+1)'(D));
    assign out_valid = (count != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_reg];

    // Storage has no reset; only pointers and count need one
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Packs up to NSIG signals into one 8-byte payload per request
module can_output_signal_packer #(
    parameter int NSIG = 10,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NSIG*32-1:0] src_value,
    input wire logic [NSIG-1:0] src_defined,
    input wire logic frame_req,
    output logic busy,
    output logic frame_valid,
    input wire logic frame_ready,
    output logic [63:0] frame_payload,
    output logic [3:0] frame_len,
    output logic [2:0] frame_prio,
    output logic [17:0] frame_pgn,
    input wire logic [31:0] boot_rate,
    output logic rate_store,
    output logic [31:0] rate_store_data,
    output logic [31:0] run_rate
);
    localparam int FW = 89;
    localparam int IW = $clog2(NSIG);

    packer_pkg::state_e state_reg;
    logic [17:0] ctrl_reg [NSIG];
    logic [31:0] res_reg [NSIG];
    logic [31:0] off_reg [NSIG];
    logic [3:0] len_reg;
    logic [2:0] prio_reg;
    logic [17:0] pgn_reg;
    logic reject_reg;
    logic cap_done_reg;
    logic [IW-1:0] idx_reg;
    logic [63:0] payload_reg;
    logic [32:0] quo_reg;
    logic [32:0] rem_reg;
    logic [32:0] code_reg;
    logic [5:0] step_reg;
    logic fifo_in_ready;
    logic [$clog2(DEPTH):0] fifo_count;
    logic [FW-1:0] fifo_out;
    logic sig_hit;
    logic [3:0] sig_idx;
    logic [33:0] diff;
    logic [32:0] rem_sh;
    logic [5:0] cur_size;
    logic [5:0] cur_start;
    logic [63:0] cur_mask;
    logic [32:0] cur_max;
    logic [32:0] quo_fin;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Upper limit of the continuous code range for a field width
    function automatic logic [32:0] range_max(input logic [5:0] n);
        logic [32:0] ones;
        ones = (33'h1 << n) - 33'h1;
        if (n >= 6'h08) begin
            range_max = ones - (33'h5 << (n - 6'h08));
        end else begin
            range_max = ones - 33'h1;
        end
    endfunction

    // First payload bit from one-based byte and bit positions
    function automatic logic [5:0] start_bit(input logic [17:0] c);
        start_bit = {c[`BYTE_LSB +: 3] - 3'h1, 3'h0} + {3'h0, c[`BIT_LSB +: 3] - 3'h1};
    endfunction

    // A control word is taken only when every field is in range
    function automatic logic ctrl_ok(input logic [31:0] w);
        logic [3:0] b;
        logic [3:0] t;
        logic [5:0] s;
        b = w[`BYTE_LSB +: 4];
        t = w[`BIT_LSB +: 4];
        s = w[`SIZE_LSB +: 6];
        ctrl_ok = (w[1:0] != 2'h3) && (b >= 4'h1) && (b <= 4'h8)
            && (t >= 4'h1) && (t <= 4'h8)
            && (s >= 6'h01) && (s <= 6'h20);
    endfunction

    // Reset control word of each signal
    function automatic logic [17:0] ctrl_def(input int i);
        if (i == 0) begin
            ctrl_def = {`SIZE_WORD, `BIT_ONE, `BYTE_ONE, 2'h0, 2'(packer_pkg::SIG_CONT)};
        end else if (i == 1) begin
            ctrl_def = {`SIZE_WORD, `BIT_ONE, `BYTE_SECOND, 2'h0, 2'(packer_pkg::SIG_CONT)};
        end else begin
            ctrl_def = {`SIZE_ONE, `BIT_ONE, `BYTE_ONE, 2'h0, 2'(packer_pkg::SIG_UNDEF)};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode

    assign sig_hit = (reg_addr >= `A_SIG_BASE) && (reg_addr <= `A_SIG_LAST) && (reg_addr[3:2] != 2'h3);
    assign sig_idx = 4'(8'(reg_addr - `A_SIG_BASE) >> 4);

    // Per-signal parameters, all reachable by the remote configurator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NSIG; i++) begin
                ctrl_reg[i] <= ctrl_def(i);
                res_reg[i] <= (i < 2) ? `RES_FINE : `RES_ONE;
                off_reg[i] <= (i < 2) ? `OFF_FINE : `OFF_ZERO;
            end
        end else if (reg_wr && sig_hit && 32'(sig_idx) < NSIG) begin
            unique case (reg_addr[3:2])
                `F_CTRL: begin
                    if (ctrl_ok(reg_wdata)) begin
                        ctrl_reg[sig_idx] <= reg_wdata[17:0];
                    end
                end
                `F_RES: res_reg[sig_idx] <= reg_wdata;
                `F_OFF: off_reg[sig_idx] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Message-wide settings; an out-of-range word leaves the field alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            len_reg <= `LEN_RST;
            prio_reg <= `PRIO_RST;
            pgn_reg <= `PGN_RST;
            reject_reg <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `A_GCTRL && reg_wdata[`LEN_LSB +: 4] <= `LEN_MAX) begin
                len_reg <= reg_wdata[`LEN_LSB +: 4];
                prio_reg <= reg_wdata[`PRIO_LSB +: 3];
            end
            if (reg_addr == `A_PGN) begin
                if (reg_wdata[17:0] == `PGN_RSVD) begin
                    reject_reg <= 1'b1;
                end else begin
                    pgn_reg <= reg_wdata[17:0];
                    reject_reg <= 1'b0;
                end
            end
        end
    end

    // New bit rate goes to storage only; the running rate is caught at boot
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rate_store <= 1'b0;
            rate_store_data <= '0;
            run_rate <= '0;
            cap_done_reg <= 1'b0;
        end else begin
            rate_store <= reg_wr && (reg_addr == `A_RATE);
            if (reg_wr && reg_addr == `A_RATE) begin
                rate_store_data <= reg_wdata;
            end
            if (!cap_done_reg) begin
                run_rate <= boot_rate;
                cap_done_reg <= 1'b1;
            end
        end
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            if (reg_addr == `A_GCTRL) begin
                reg_rdata <= {25'h0, prio_reg, len_reg};
            end else if (reg_addr == `A_PGN) begin
                reg_rdata <= {14'h0, pgn_reg};
            end else if (reg_addr == `A_STAT) begin
                reg_rdata <= {16'h0, 10'(fifo_count), busy, reject_reg, 1'b0, 3'(state_reg)};
            end else if (reg_addr == `A_RATE) begin
                reg_rdata <= run_rate;
            end else if (sig_hit && 32'(sig_idx) < NSIG) begin
                unique case (reg_addr[3:2])
                    `F_CTRL: reg_rdata <= {14'h0, ctrl_reg[sig_idx]};
                    `F_RES: reg_rdata <= res_reg[sig_idx];
                    `F_OFF: reg_rdata <= off_reg[sig_idx];
                    default: reg_rdata <= '0;
                endcase
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Encoding and packing engine, one signal at a time

    assign cur_size = ctrl_reg[idx_reg][`SIZE_LSB +: 6];
    assign cur_start = start_bit(ctrl_reg[idx_reg]);
    assign cur_mask = (64'h1 << cur_size) - 64'h1;
    assign cur_max = range_max(cur_size);
    // Half a step added up front rounds to nearest instead of truncating
    assign diff = {{2{src_value[idx_reg*32+31]}}, src_value[idx_reg*32 +: 32]}
        - {{2{off_reg[idx_reg][31]}}, off_reg[idx_reg]}
        + {3'h0, res_reg[idx_reg][31:1]};
    assign rem_sh = {rem_reg[31:0], quo_reg[32]};
    // Last quotient bit is settled only in the final step, so fold it in here
    assign quo_fin = {quo_reg[31:0], rem_sh >= {1'b0, res_reg[idx_reg]}};
    assign busy = (state_reg != packer_pkg::ST_IDLE);

    // Sequencer; a full FIFO holds it in push, back-pressuring requests
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= packer_pkg::ST_IDLE;
            idx_reg <= '0;
            step_reg <= '0;
        end else begin
            unique case (state_reg)
                packer_pkg::ST_IDLE: begin
                    idx_reg <= '0;
                    if (frame_req) begin
                        state_reg <= packer_pkg::ST_LOAD;
                    end
                end
                packer_pkg::ST_LOAD: begin
                    step_reg <= `DIV_STEPS;
                    state_reg <= packer_pkg::ST_DIV;
                end
                packer_pkg::ST_DIV: begin
                    step_reg <= step_reg - 6'h01;
                    if (step_reg == 6'h01) begin
                        state_reg <= packer_pkg::ST_PACK;
                    end
                end
                packer_pkg::ST_PACK: begin
                    if (32'(idx_reg) == NSIG - 1) begin
                        state_reg <= packer_pkg::ST_PUSH;
                    end else begin
                        idx_reg <= idx_reg + 1'b1;
                        state_reg <= packer_pkg::ST_LOAD;
                    end
                end
                packer_pkg::ST_PUSH: begin
                    if (fifo_in_ready) begin
                        state_reg <= packer_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Restoring divider; it always runs the full count so timing is fixed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quo_reg <= '0;
            rem_reg <= '0;
        end else if (state_reg == packer_pkg::ST_LOAD) begin
            quo_reg <= diff[33] ? 33'h0 : diff[32:0];
            rem_reg <= '0;
        end else if (state_reg == packer_pkg::ST_DIV) begin
            if (rem_sh >= {1'b0, res_reg[idx_reg]}) begin
                rem_reg <= rem_sh - {1'b0, res_reg[idx_reg]};
                quo_reg <= {quo_reg[31:0], 1'b1};
            end else begin
                rem_reg <= rem_sh;
                quo_reg <= {quo_reg[31:0], 1'b0};
            end
        end
    end

    // Field code per type; chosen in the last divide step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            code_reg <= '0;
        end else if (state_reg == packer_pkg::ST_DIV && step_reg == 6'h01) begin
            if (ctrl_reg[idx_reg][1:0] == 2'(packer_pkg::SIG_UNDEF) || !src_defined[idx_reg]) begin
                code_reg <= {1'b0, cur_mask[31:0]};
            end else if (ctrl_reg[idx_reg][1:0] == 2'(packer_pkg::SIG_DISC)) begin
                code_reg <= {1'b0, src_value[idx_reg*32 +: 32]} & {1'b0, cur_mask[31:0]};
            end else if (res_reg[idx_reg] == '0 || diff[33]) begin
                // Negative saturates low, even at zero resolution; otherwise zero resolution saturates high
                code_reg <= diff[33] ? 33'h0 : cur_max;
            end else begin
                code_reg <= (quo_fin > cur_max) ? cur_max : quo_fin;
            end
        end
    end

    // Insert the field; bits above 63 fall off, untouched bits stay ones
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            payload_reg <= '1;
        end else if (state_reg == packer_pkg::ST_IDLE) begin
            payload_reg <= '1;
        end else if (state_reg == packer_pkg::ST_PACK) begin
            payload_reg <= (payload_reg & ~(cur_mask << cur_start))
                | (({31'h0, code_reg} & cur_mask) << cur_start);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame FIFO

    frame_fifo #(.W(FW), .D(DEPTH)) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(state_reg == packer_pkg::ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data({pgn_reg, prio_reg, len_reg, payload_reg}),
        .out_valid(frame_valid),
        .out_ready(frame_ready),
        .out_data(fifo_out),
        .count(fifo_count)
    );

    assign frame_payload = fifo_out[63:0];
    assign frame_len = fifo_out[67:64];
    assign frame_prio = fifo_out[70:68];
    assign frame_pgn = fifo_out[88:71];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_pgn_reserved: assert property (reg_wr && reg_addr == `A_PGN && reg_wdata[17:0] == `PGN_RSVD
        |=> $stable(pgn_reg) && reject_reg) else $error("reserved group number taken");
    a_len_bad_kept: assert property (reg_wr && reg_addr == `A_GCTRL && reg_wdata[3:0] > `LEN_MAX
        |=> $stable(len_reg)) else $error("length above eight taken");
    a_start_in_frame: assert property (cur_start <= 6'h3f && start_bit(ctrl_reg[idx_reg]) ==
        6'(8 * (ctrl_reg[idx_reg][6:4] - 1) + ctrl_reg[idx_reg][10:8] - 1)) else $error("start bit wrong");
    a_undef_ones: assert property (state_reg == packer_pkg::ST_PACK
        && ctrl_reg[idx_reg][1:0] == 2'(packer_pkg::SIG_UNDEF) |-> code_reg == {1'b0, cur_mask[31:0]})
        else $error("undefined field not all ones");
    a_disc_copy: assert property (state_reg == packer_pkg::ST_PACK && src_defined[idx_reg]
        && ctrl_reg[idx_reg][1:0] == 2'(packer_pkg::SIG_DISC)
        |-> code_reg[31:0] == (src_value[idx_reg*32 +: 32] & cur_mask[31:0])) else $error("discrete altered");
    a_cont_clamp: assert property (state_reg == packer_pkg::ST_PACK && src_defined[idx_reg]
        && ctrl_reg[idx_reg][1:0] == 2'(packer_pkg::SIG_CONT) |-> code_reg <= cur_max)
        else $error("continuous code out of range");
    a_div_length: assert property ($rose(state_reg == packer_pkg::ST_DIV)
        |-> (state_reg == packer_pkg::ST_DIV) [*8] ##26 state_reg == packer_pkg::ST_PACK)
        else $error("divide length wrong");
    a_rate_fixed: assert property (cap_done_reg && $past(cap_done_reg) |-> $stable(run_rate))
        else $error("running rate changed");
    a_field_placed: assert property (state_reg == packer_pkg::ST_PACK |=>
        ((payload_reg >> $past(cur_start)) & $past(cur_mask)) == ($past({31'h0, code_reg}) & $past(cur_mask) &
        (64'hffffffffffffffff >> $past(cur_start)))) else $error("field misplaced");
    a_rd_unmapped: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == '0)
        else $error("unmapped read not zero");

    c_frame_out: cover property (frame_valid && frame_ready);
    c_fifo_full: cover property (state_reg == packer_pkg::ST_PUSH && !fifo_in_ready);
    c_reject: cover property (reg_wr && reg_addr == `A_PGN && reg_wdata[17:0] == `PGN_RSVD);
    c_clamp_high: cover property (state_reg == packer_pkg::ST_PACK && code_reg == cur_max
        && ctrl_reg[idx_reg][1:0] == 2'(packer_pkg::SIG_CONT));
endmodule

// >>> frame_sink.sv
// Model of the bus-side consumer that takes packed frames out of the FIFO
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module frame_sink (
    input wire logic clk,
    input wire logic resetn,
    input wire logic stall,
    input wire logic frame_valid,
    output logic frame_ready,
    input wire logic [63:0] frame_payload,
    input wire logic [3:0] frame_len,
    input wire logic [2:0] frame_prio,
    input wire logic [17:0] frame_pgn,
    output logic [63:0] got_payload,
    output logic [3:0] got_len,
    output logic [2:0] got_prio,
    output logic [17:0] got_pgn,
    output logic [15:0] got_count
);
    // A stalled bus refuses the head frame, so the FIFO backs up
    assign frame_ready = !stall;

    // Latch each frame taken; bit 0 is byte one bit one on the wire
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            got_payload <= 64'h0;
            got_len <= 4'h0;
            got_prio <= 3'h0;
            got_pgn <= 18'h0;
            got_count <= 16'h0;
        end else if (frame_valid && frame_ready) begin
            got_payload <= frame_payload;
            got_len <= frame_len;
            got_prio <= frame_prio;
            got_pgn <= frame_pgn;
            got_count <= got_count + 16'h1;
        end
    end
endmodule

// >>> packer_cfg.svh
// Constants for the output signal packer: offsets, fields, reset values, counts
`ifndef PACKER_CFG_SVH
`define PACKER_CFG_SVH

// Register offsets
`define A_GCTRL 8'h00
`define A_PGN 8'h04
`define A_STAT 8'h08
`define A_RATE 8'h0c
`define A_SIG_BASE 8'h40
`define A_SIG_LAST 8'hdc
`define F_CTRL 2'h0
`define F_RES 2'h1
`define F_OFF 2'h2

// Field positions
`define TYPE_LSB 0
`define BYTE_LSB 4
`define BIT_LSB 8
`define SIZE_LSB 12
`define LEN_LSB 0
`define PRIO_LSB 4

// Reset values, length limit and reserved group number
`define LEN_RST 4'h8
`define LEN_MAX 4'h8
`define PRIO_RST 3'h3
`define PGN_RST 18'h0f013
`define PGN_RSVD 18'h0ef00
`define RES_FINE 32'h00000083
`define OFF_FINE 32'hffc00000
`define RES_ONE 32'h00010000
`define OFF_ZERO 32'h00000000
`define SIZE_WORD 6'h10
`define SIZE_ONE 6'h01
`define BYTE_ONE 4'h1
`define BYTE_SECOND 4'h3
`define BIT_ONE 4'h1

// Timing counts
`define DIV_STEPS 6'h21

`endif

// >>> packer_pkg.sv
// Types shared by the output signal packer
package packer_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_DIV = 3'b011,
        ST_PACK = 3'b010,
        ST_PUSH = 3'b110
    } state_e;
    typedef enum logic [1:0] {
        SIG_UNDEF = 2'h0,
        SIG_DISC = 2'h1,
        SIG_CONT = 2'h2
    } sig_type_e;
endpackage

// >>> tb_top.sv
// Self-checking bench for the output signal packer
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, frame_req = 1'b0, stall = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, boot_rate = 32'h0003d090, rd_data;
    logic [319:0] src_value = 320'h0;
    logic [9:0] src_defined = 10'h3ff;
    logic busy, frame_valid, frame_ready, rate_store;
    logic [31:0] reg_rdata, rate_store_data, run_rate;
    logic [63:0] frame_payload, got_payload;
    logic [3:0] frame_len, got_len;
    logic [2:0] frame_prio, got_prio;
    logic [17:0] frame_pgn, got_pgn;
    logic [15:0] got_count, base;
    int fail_count = 0, checks = 0;

    always #2.5 clk = ~clk;

    can_output_signal_packer #(.NSIG(10), .DEPTH(32)) dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_value(src_value),
        .src_defined(src_defined), .frame_req(frame_req), .busy(busy), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .frame_payload(frame_payload), .frame_len(frame_len), .frame_prio(frame_prio),
        .frame_pgn(frame_pgn), .boot_rate(boot_rate), .rate_store(rate_store), .rate_store_data(rate_store_data),
        .run_rate(run_rate));
    frame_sink sink_u (.clk(clk), .resetn(resetn), .stall(stall), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .frame_payload(frame_payload), .frame_len(frame_len), .frame_prio(frame_prio),
        .frame_pgn(frame_pgn), .got_payload(got_payload), .got_len(got_len), .got_prio(got_prio),
        .got_pgn(got_pgn), .got_count(got_count));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared compare, bus cycles and frame helpers
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_data = reg_rdata;
    endtask
    task automatic pack(input int extra);
        int n;
        @(posedge clk);
        frame_req <= 1'b1;
        repeat (1 + extra) @(posedge clk);
        frame_req <= 1'b0;
        #1 check("busy", busy, 1'b1);
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) check("busy_timeout", 1'b1, 1'b0);
        repeat (3) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_defaults;
        rd(8'h00); check("gctrl", rd_data, 32'h38);
        rd(8'h04); check("pgn", rd_data, 32'hf013);
        rd(8'h40); check("sig0_ctrl", rd_data, 32'h10112);
        rd(8'h50); check("sig1_ctrl", rd_data, 32'h10132);
        rd(8'h44); check("sig0_res", rd_data, 32'h83);
        rd(8'h58); check("sig1_off", rd_data, 32'hffc00000);
        rd(8'hd0); check("sig9_ctrl", rd_data, 32'h1110);
        rd(8'hd4); check("sig9_res", rd_data, 32'h10000);
        rd(8'hd8); check("sig9_off", rd_data, 32'h0);
        rd(8'h4c); check("unmapped", rd_data, 32'h0);
    endtask
    // Default layout: sig0 code zero, sig1 forced undefined, sig2 to sig9 each set bit 0
    task automatic t_default_frame;
        src_value[31:0] <= 32'hffc00000;
        src_defined <= 10'h3fd;
        base = got_count;
        pack(0);
        check("frames", got_count, base + 16'h1);
        check("payload_def", got_payload, 64'hffffffff_ffff0001);
        check("len_def", got_len, 4'h8);
        check("prio_def", got_prio, 3'h3);
        src_defined <= 10'h3ff;
    endtask
    task automatic t_rate;
        check("run_rate", run_rate, 32'h0003d090);
        wr(8'h0c, 32'h0007a120);
        // Store pulse stands in the cycle right after the write edge
        #1 check("rate_store", rate_store, 1'b1);
        check("rate_data", rate_store_data, 32'h0007a120);
        rd(8'h0c); check("rate_kept", rd_data, 32'h0003d090);
    endtask
    task automatic t_pgn_reject;
        wr(8'h04, 32'hef00);
        rd(8'h04); check("pgn_rej", rd_data, 32'hf013);
        rd(8'h08); check("rej_flag", rd_data[4], 1'b1);
        wr(8'h04, 32'h1234);
        rd(8'h08); check("rej_clear", rd_data[4], 1'b0);
    endtask
    // Custom layout, saturation, rounding, negative clamp, refused request; only the undefined one-bit fields overlap, at bit 0
    task automatic t_config_frame;
        wr(8'h40, 32'h8182); wr(8'h44, 32'h10000); wr(8'h48, 32'h0);
        wr(8'h50, 32'h4321);
        wr(8'h60, 32'h8142); wr(8'h64, 32'h10000); wr(8'h68, 32'h20000);
        wr(8'h70, 32'h8152); wr(8'h74, 32'h10000); wr(8'h78, 32'h0);
        wr(8'h70, 32'h8153);
        rd(8'h70); check("ctrl_type3", rd_data, 32'h8152);
        wr(8'h00, 32'h65); wr(8'h00, 32'h69);
        rd(8'h00); check("gctrl_len9", rd_data, 32'h65);
        src_value[127:0] <= {32'hfff00000, 32'h00078000, 32'h00000025, 32'h01000000};
        base = got_count;
        pack(1);
        check("one_frame", got_count, base + 16'h1);
        check("payload_cfg", got_payload, 64'hfaffff00_06ffd7ff);
        check("len_cfg", got_len, 4'h5);
        check("prio_cfg", got_prio, 3'h6);
        check("pgn_cfg", got_pgn, 18'h01234);
    endtask
    // Fill the 32-deep FIFO with the bus stalled, then drain it
    task automatic t_fill;
        int n;
        stall <= 1'b1;
        base = got_count;
        repeat (32) pack(0);
        rd(8'h08); check("fifo_count", rd_data[15:6], 10'd32);
        @(posedge clk);
        frame_req <= 1'b1;
        @(posedge clk);
        frame_req <= 1'b0;
        repeat (400) @(posedge clk);
        #1 check("busy_full", busy, 1'b1);
        stall <= 1'b0;
        n = 0;
        while (got_count !== base + 16'd33 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        #1 check("drained", got_count, base + 16'd33);
        check("empty", frame_valid, 1'b0);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        t_defaults;
        t_default_frame;
        t_rate;
        t_pgn_reject;
        t_config_frame;
        t_fill;
        end_of_test;
    end

    // Runs far longer than the whole sequence should take
    initial begin
        #(60000 * 5);
        fail_count++;
        end_of_test;
    end
endmodule
